// *** logic/smp_pkg.sv ***
// Purpose: shared constants and types for the serial programming port
// Assumes: both ends run their own clock at 250 MHz
// Notes: opcodes, field positions, polling values and wait counts
`default_nettype none
package smp_pkg;
    // instruction encodings
    localparam logic [7:0] OP_PRIV = 8'hac;
    localparam logic [7:0] OP_ENABLE2 = 8'h53;
    localparam logic [2:0] OP_ERASE2 = 3'h4;
    localparam logic [4:0] OP_LOCK2 = 5'h1f;
    localparam logic [2:0] OP_FUSE2 = 3'h5;
    localparam logic [3:0] OP_PM_RD = 4'h2;
    localparam logic [3:0] OP_PM_WR = 4'h4;
    localparam logic [7:0] OP_EE_RD = 8'ha0;
    localparam logic [7:0] OP_EE_WR = 8'hc0;
    localparam logic [7:0] OP_LOCK_RD = 8'h58;
    localparam logic [7:0] OP_SIG_RD = 8'h30;
    localparam logic [7:0] OP_FUSE_RD = 8'h50;
    // field positions
    localparam int unsigned HI_BYTE_BIT = 3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] BYTE3_END = 5'h17;
    localparam logic [4:0] INSN_END = 5'h1f;
    localparam logic [5:0] INSN_BITS = 6'h20;
    // readback values
    localparam logic [7:0] ERASE_PHASE_READBACK = 8'h00;
    localparam logic [7:0] WRITE_PHASE_READBACK = 8'hff;
    localparam logic [7:0] FLASH_POLL = 8'hff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] SIG_HIDDEN = 8'h00;
    localparam logic [1:0] LOCK_ERASED = 2'h3;
    localparam logic [1:0] LOCK_ALL = 2'h0;
    localparam logic [5:0] FUSE_RESET = 6'h1f;
    // memory sizes
    localparam int unsigned PM_WORDS = 2048;
    localparam int unsigned EE_BYTES = 256;
    // timing, figures in their own units
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned MIN_BYTE_WRITE_WAIT_MS = 9;
    localparam int unsigned MIN_ERASE_WAIT_MS = 18;
    localparam int unsigned DEV_WRITE_MS = 4;
    localparam int unsigned DEV_ERASE_MS = 8;
    localparam int unsigned MIN_BYTE_WRITE_WAIT_CYC =
        MIN_BYTE_WRITE_WAIT_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned MIN_ERASE_WAIT_CYC =
        MIN_ERASE_WAIT_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned DEV_WRITE_CYC =
        DEV_WRITE_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned DEV_ERASE_CYC =
        DEV_ERASE_MS * NS_PER_MS / CLK_PERIOD_NS;
    // serial clock half period in own clocks, at least two osc periods
    localparam logic [7:0] SCK_HALF_CYC = 8'h04;
    localparam logic [5:0] RESYNC_TRIES = 6'h20;
    // kind of pending nonvolatile operation
    typedef enum logic [1:0] {
        WK_NONE = 2'b00,
        WK_PM = 2'b01,
        WK_EE = 2'b10,
        WK_ERASE = 2'b11
    } smp_wkind_t;

    // program memory opcode test, high byte flag ignored
    function automatic logic is_pm(input logic [7:0] b,
                                   input logic [3:0] op);
        return (b[7:4] == op) && (b[2:0] == 3'h0);
    endfunction
endpackage
`default_nettype wire

// *** logic/smp_link_if.sv ***
// Purpose: serial programming link between programmer and device
// Assumes: programmer drives clock, data in and target reset
// Notes: no two-way pins on this link
`default_nettype none
interface smp_link_if;
    logic sck;
    logic mosi;
    logic miso;
    logic tgt_reset_n;

    modport dev(input sck, input mosi, input tgt_reset_n, output miso);
    modport prog(output sck, output mosi, output tgt_reset_n, input miso);
endinterface
`default_nettype wire

// *** logic/smp_dev.sv ***
// Purpose: device end of the serial programming port
// Assumes: link logic clocked by sck, timers by the device clock clk
// Notes: memories, lock and fuse bits kept in sck domain
`default_nettype none
module smp_dev import smp_pkg::*; #(
    parameter int unsigned WRITE_CYC = DEV_WRITE_CYC,
    parameter int unsigned ERASE_CYC = DEV_ERASE_CYC,
    parameter logic [7:0] SIG_0 = 8'h5a, // arbitrary value
    parameter logic [7:0] SIG_1 = 8'h3c, // arbitrary value
    parameter logic [7:0] SIG_2 = 8'h0f  // arbitrary value
) (
    // link
    smp_link_if.dev lk,
    // device clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // status
    output logic prog_enabled,
    output logic nv_busy,
    output logic [1:0] protect_bits,
    output logic [5:0] fuse_bits
);
    typedef struct packed {
        logic [4:0] cnt;
        logic [31:0] sh;
        logic [7:0] tx;
        logic en;
        logic req_t;
        smp_wkind_t pk;
        logic [11:0] pa;
        logic [1:0] ack_s;
        logic [1:0] ph_s;
    } smp_lnk_t;

    typedef struct packed {
        logic [1:0] locks;
        logic [5:0] fuses;
    } smp_nv_t;

    typedef struct packed {
        logic [2:0] rq_s;
        logic [1:0] en_s;
        logic ack_t;
        logic busy;
        logic ph;
        logic [31:0] cnt;
    } smp_clk_t;

    smp_lnk_t l_q, l_d;
    smp_nv_t nv_q, nv_d;
    smp_clk_t c_q, c_d;
    logic miso_q;
    logic lrst_n;
    logic [7:0] pm_lo [PM_WORDS];
    logic [7:0] pm_hi [PM_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [7:0] b1, b2, b3, b4, rd_val;
    logic [11:0] rd_pa;
    logic rd_hit, pend;
    logic pm_we, ee_we, erase_all;

    // link logic held in reset while target reset pin is high
    assign lrst_n = rst_n & ~lk.tgt_reset_n;

    // a write or erase is pending until its ack toggle comes back
    assign pend = l_q.req_t != l_q.ack_s[1];

    // read value for byte four, looked up when byte three ends
    always_comb begin
        // same bytes the shifter holds after this edge, no loop
        b1 = l_q.sh[22:15];
        b2 = l_q.sh[14:7];
        b3 = {l_q.sh[6:0], lk.mosi};
        rd_pa = {b1[HI_BYTE_BIT], b2[2:0], b3};
        rd_hit = 1'b1;
        rd_val = ERASED_BYTE;
        if (is_pm(b1, OP_PM_RD)) begin
            if (pend && l_q.pk == WK_PM && rd_pa == l_q.pa) begin
                rd_val = FLASH_POLL;
            end else if (b1[HI_BYTE_BIT]) begin
                rd_val = pm_hi[rd_pa[10:0]];
            end else begin
                rd_val = pm_lo[rd_pa[10:0]];
            end
        end else if (b1 == OP_EE_RD) begin
            if (pend && l_q.pk == WK_EE && b3 == l_q.pa[7:0]) begin
                rd_val = l_q.ph_s[1] ? WRITE_PHASE_READBACK
                                     : ERASE_PHASE_READBACK;
            end else begin
                rd_val = ee_mem[b3];
            end
        end else if (b1 == OP_LOCK_RD) begin
            rd_val = {5'h1f, nv_q.locks, 1'b1};
        end else if (b1 == OP_SIG_RD) begin
            if (nv_q.locks == LOCK_ALL) begin
                rd_val = SIG_HIDDEN;
            end else if (b3[1:0] == 2'h0) begin
                rd_val = SIG_0;
            end else if (b3[1:0] == 2'h1) begin
                rd_val = SIG_1;
            end else if (b3[1:0] == 2'h2) begin
                rd_val = SIG_2;
            end
        end else if (b1 == OP_FUSE_RD) begin
            rd_val = {2'h3, nv_q.fuses};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // shift, echo and decode on each rising sck
    always_comb begin
        l_d = l_q;
        nv_d = nv_q;
        pm_we = 1'b0;
        ee_we = 1'b0;
        erase_all = 1'b0;
        l_d.cnt = l_q.cnt + 5'h01;
        l_d.sh = {l_q.sh[30:0], lk.mosi};
        l_d.ack_s = {l_q.ack_s[0], c_q.ack_t};
        l_d.ph_s = {l_q.ph_s[0], c_q.ph};
        b4 = l_d.sh[7:0];
        // each finished byte is echoed during the next one, except byte three of a read, replaced by the read value
        if (l_q.cnt[2:0] == BIT_LAST) begin
            l_d.tx = l_d.sh[7:0];
        end
        if (l_q.cnt == BYTE3_END && rd_hit) begin
            l_d.tx = rd_val;
        end
        if (l_q.cnt == INSN_END) begin
            if (l_d.sh[31:24] == OP_PRIV && l_d.sh[23:16] == OP_ENABLE2)
            begin
                l_d.en = 1'b1;
            end else if (!l_q.en || pend) begin
                // nothing before enable, nothing while busy
            end else if (l_d.sh[31:24] == OP_PRIV) begin
                if (l_d.sh[23:21] == OP_ERASE2) begin
                    erase_all = 1'b1;
                    nv_d.locks = LOCK_ERASED;
                    l_d.pk = WK_ERASE;
                    l_d.req_t = ~l_q.req_t;
                end else if (l_d.sh[23:19] == OP_LOCK2 && l_d.sh[16]) begin
                    nv_d.locks = nv_q.locks & l_d.sh[18:17];
                end else if (l_d.sh[23:21] == OP_FUSE2) begin
                    nv_d.fuses[4:0] = l_d.sh[20:16];
                end
            end else if (is_pm(l_d.sh[31:24], OP_PM_WR)) begin
                pm_we = 1'b1;
                l_d.pk = WK_PM;
                l_d.pa = {l_d.sh[27], l_d.sh[18:8]};
                l_d.req_t = ~l_q.req_t;
            end else if (l_d.sh[31:24] == OP_EE_WR) begin
                ee_we = 1'b1;
                l_d.pk = WK_EE;
                l_d.pa = {4'h0, l_d.sh[15:8]};
                l_d.req_t = ~l_q.req_t;
            end
            // any other encoding falls through unchanged
        end
    end

    // link state
    always_ff @(posedge lk.sck or negedge lrst_n) begin
        if (!lrst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // lock and fuse bits survive target reset pulses
    always_ff @(posedge lk.sck or negedge rst_n) begin
        if (!rst_n) begin
            nv_q <= {LOCK_ERASED, FUSE_RESET};
        end else begin
            nv_q <= nv_d;
        end
    end

    // outgoing bit changes on falling sck
    always_ff @(negedge lk.sck or negedge lrst_n) begin
        if (!lrst_n) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= l_q.tx[~l_q.cnt[2:0]];
        end
    end

    // memory arrays, no reset
    always_ff @(posedge lk.sck) begin
        if (erase_all) begin
            for (int i = 0; i < PM_WORDS; i++) begin
                pm_lo[i] <= ERASED_BYTE;
                pm_hi[i] <= ERASED_BYTE;
            end
            for (int i = 0; i < EE_BYTES; i++) begin
                ee_mem[i] <= ERASED_BYTE;
            end
        end else begin
            if (pm_we && l_d.pa[11]) begin
                pm_hi[l_d.pa[10:0]] <= b4;
            end
            if (pm_we && !l_d.pa[11]) begin
                pm_lo[l_d.pa[10:0]] <= b4;
            end
            if (ee_we) begin
                ee_mem[l_d.pa[7:0]] <= b4;
            end
        end
    end

    // write timer on the device clock, toggle handshake with link
    always_comb begin
        c_d = c_q;
        c_d.rq_s = {c_q.rq_s[1:0], l_q.req_t};
        c_d.en_s = {c_q.en_s[0], l_q.en};
        if (c_q.rq_s[2] != c_q.rq_s[1]) begin
            c_d.busy = 1'b1;
            c_d.ph = l_q.pk != WK_EE;
            c_d.cnt = (l_q.pk == WK_ERASE) ? 32'(ERASE_CYC)
                                           : 32'(WRITE_CYC);
        end else if (c_q.busy) begin
            if (c_q.cnt <= 32'h1) begin
                c_d.busy = 1'b0;
                c_d.ph = 1'b0;
                c_d.ack_t = ~c_q.ack_t;
            end else begin
                c_d.cnt = c_q.cnt - 32'h1;
                // eeprom auto-erase takes the first half
                if (c_d.cnt <= 32'(WRITE_CYC / 2)) begin
                    c_d.ph = 1'b1;
                end
            end
        end
    end

    // device clock state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // outputs
    assign lk.miso = miso_q;
    assign prog_enabled = c_q.en_s[1];
    assign nv_busy = c_q.busy;
    assign protect_bits = nv_q.locks;
    assign fuse_bits = nv_q.fuses;
endmodule // smp_dev
`default_nettype wire

// *** logic/smp_prog.sv ***
// Purpose: programmer end, shifts four-byte instructions to the device
// Assumes: sck made by dividing clk, miso synchronised into clk
// Notes: fixed waits after writes and erase, no data polling
`default_nettype none
module smp_prog import smp_pkg::*; #(
    parameter int unsigned BYTE_WAIT_CYC = MIN_BYTE_WRITE_WAIT_CYC,
    parameter int unsigned ERASE_WAIT_CYC = MIN_ERASE_WAIT_CYC
) (
    // link
    smp_link_if.prog lk,
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // session control
    input wire logic session,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [31:0] cmd_word,
    // response
    output logic rsp_valid,
    output logic [31:0] rsp_word,
    output logic rsp_fail
);
    typedef enum logic [2:0] {
        PS_IDLE = 3'b000,
        PS_LOW = 3'b001,
        PS_HIGH = 3'b010,
        PS_PULSE = 3'b011,
        PS_PULSE_LOW = 3'b100,
        PS_WAIT = 3'b101
    } smp_pst_t;

    typedef struct packed {
        smp_pst_t st;
        logic [7:0] div;
        logic [5:0] bits;
        logic [31:0] cmd;
        logic [31:0] tx;
        logic [31:0] rx;
        logic sck;
        logic mosi;
        logic rstn;
        logic [31:0] wt;
        logic [5:0] tries;
        logic erased;
        logic rv;
        logic rf;
        logic [1:0] miso_s;
    } smp_prog_t;

    smp_prog_t q, d;
    logic skip;

    // shifting, resync and post-write waits
    always_comb begin
        d = q;
        d.rv = 1'b0;
        d.miso_s = {q.miso_s[0], lk.miso};
        d.rstn = ~session;
        d.div = q.div + 8'h01;
        // ff after an erase needs no write
        skip = q.erased && cmd_word[7:0] == ERASED_BYTE &&
               (is_pm(cmd_word[31:24], OP_PM_WR) ||
                cmd_word[31:24] == OP_EE_WR);
        case (q.st)
            PS_IDLE: begin
                d.div = 8'h00;
                if (cmd_valid && skip) begin
                    d.rv = 1'b1;
                    d.rf = 1'b0;
                    d.rx = '0;
                end else if (cmd_valid) begin
                    d.cmd = cmd_word;
                    d.tx = cmd_word;
                    d.bits = '0;
                    d.tries = '0;
                    d.st = PS_LOW;
                end
            end
            PS_LOW: begin
                d.mosi = q.tx[31]; // msb first
                if (q.div == SCK_HALF_CYC - 8'h01) begin
                    d.div = 8'h00;
                    d.sck = 1'b1;
                    d.st = PS_HIGH;
                end
            end
            PS_HIGH: begin
                if (q.div == SCK_HALF_CYC - 8'h01) begin
                    d.div = 8'h00;
                    d.sck = 1'b0;
                    d.rx = {q.rx[30:0], q.miso_s[1]};
                    d.tx = {q.tx[30:0], 1'b0};
                    d.bits = q.bits + 6'h01;
                    d.st = PS_LOW;
                    if (q.bits == INSN_BITS - 6'h01) begin
                        d.st = PS_WAIT;
                        d.wt = '0;
                        if (q.cmd[31:24] == OP_PRIV &&
                            q.cmd[23:16] == OP_ENABLE2) begin
                            // echo of the second byte
                            if (d.rx[15:8] != OP_ENABLE2) begin
                                d.tries = q.tries + 6'h01;
                                d.st = (d.tries == RESYNC_TRIES) ?
                                       PS_WAIT : PS_PULSE;
                            end
                        end else if (q.cmd[31:24] == OP_PRIV &&
                                     q.cmd[23:21] == OP_ERASE2) begin
                            d.wt = 32'(ERASE_WAIT_CYC);
                            d.erased = 1'b1;
                        end else if (is_pm(q.cmd[31:24], OP_PM_WR) ||
                                     q.cmd[31:24] == OP_EE_WR) begin
                            d.wt = 32'(BYTE_WAIT_CYC);
                        end
                    end
                end
            end
            PS_PULSE: begin
                // one extra clock pulse to slip the bit framing
                if (q.div == SCK_HALF_CYC - 8'h01) begin
                    d.div = 8'h00;
                    d.sck = ~q.sck;
                    d.st = q.sck ? PS_PULSE_LOW : PS_PULSE;
                end
            end
            PS_PULSE_LOW: begin
                if (q.div == SCK_HALF_CYC - 8'h01) begin
                    d.tx = q.cmd;
                    d.bits = '0;
                    d.div = 8'h00;
                    d.st = PS_LOW;
                end
            end
            PS_WAIT: begin
                if (q.wt == 32'h0) begin
                    d.rv = 1'b1;
                    d.rf = q.tries == RESYNC_TRIES;
                    d.st = PS_IDLE;
                end else begin
                    d.wt = q.wt - 32'h1;
                end
            end
            default: begin
                d.st = PS_IDLE;
            end
        endcase
        if (!session) begin
            d.erased = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: PS_IDLE, rstn: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs
    assign cmd_ready = q.st == PS_IDLE;
    assign rsp_valid = q.rv;
    assign rsp_word = q.rx;
    assign rsp_fail = q.rf;
    assign lk.sck = q.sck;
    assign lk.mosi = q.mosi;
    assign lk.tgt_reset_n = q.rstn;
endmodule // smp_prog
`default_nettype wire

// *** dv/smp_link_props.sv ***
// Purpose: link checks between programmer end and device end
// Assumes: sck and mosi are flops of the programmer clock
// Notes: echo checks assume no resync pulse during the run
`default_nettype none
module smp_link_props import smp_pkg::*; (
    // programmer clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic tgt_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_q;
    logic [5:0] cnt_q;
    logic [15:0] mo_q;
    logic [7:0] mi_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // capture both data lines at every rising serial clock while the target reset pin is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            cnt_q <= 6'h00;
            mo_q <= 16'h0000;
            mi_q <= 8'h00;
        end else begin
            sck_q <= sck;
            if (tgt_reset_n) begin
                cnt_q <= 6'h00;
            end else if (sck && !sck_q) begin
                cnt_q <= (cnt_q == 6'h20) ? 6'h01 : cnt_q + 6'h01;
                mo_q <= {mo_q[14:0], mosi};
                mi_q <= {mi_q[6:0], miso};
            end
        end
    end

    // edges of the serial clock
    sequence s_rise;
        !sck ##1 sck;
    endsequence
    sequence s_fall;
        sck ##1 !sck;
    endsequence

    a_sck_high_width: assert property (s_rise |-> sck[*4])
        else $error("serial clock high phase too short");
    a_sck_low_width: assert property (s_fall |-> !sck[*4])
        else $error("serial clock low phase too short");
    a_sck_in_reset: assert property (s_rise |-> !tgt_reset_n)
        else $error("serial clock pulsed with target out of reset");
    a_mosi_stable_high: assert property (sck |-> $stable(mosi))
        else $error("data to device moved while clock high");
    a_miso_low_phase: assert property ($changed(miso) |-> !sck)
        else $error("data from device moved while clock high");
    a_miso_idle_low: assert property (
        tgt_reset_n && $past(tgt_reset_n) |-> !miso)
        else $error("device drives data while not selected");
    a_echo_byte_two: assert property (
        cnt_q == 6'h10 && $changed(cnt_q) |-> mi_q == mo_q[15:8])
        else $error("second byte did not echo the first");
    a_echo_byte_three: assert property (
        cnt_q == 6'h18 && $changed(cnt_q) |-> mi_q == mo_q[15:8])
        else $error("third byte did not echo the second");
endmodule // smp_link_props
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: drives the programmer end against the device end
// Assumes: short write and erase times set by parameters
// Notes: programmer never polls, so readback is seen after waits
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smp_pkg::*;
    logic clk = 1'b0;
    logic dclk = 1'b0;
    logic rst_n = 1'b0;
    logic session = 1'b0;
    logic cmd_valid = 1'b0;
    logic [31:0] cmd_word = 32'h0;
    logic cmd_ready, rsp_valid, rsp_fail, prog_enabled, nv_busy;
    logic [31:0] rsp_word;
    logic [1:0] protect_bits;
    logic [5:0] fuse_bits;
    logic [31:0] r;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    // programmer clock and an unrelated device clock
    always #2 clk = ~clk;
    initial begin
        #1.3;
        forever #2 dclk = ~dclk;
    end

    smp_link_if lk();
    // signature bytes left at the device's own arbitrary defaults
    smp_dev #(.WRITE_CYC(200), .ERASE_CYC(400)) i_smp_dev (
        .lk(lk), .clk(dclk), .rst_n(rst_n),
        .prog_enabled(prog_enabled), .nv_busy(nv_busy),
        .protect_bits(protect_bits), .fuse_bits(fuse_bits));
    smp_prog #(.BYTE_WAIT_CYC(2000), .ERASE_WAIT_CYC(4000)) i_smp_prog (
        .lk(lk), .clk(clk), .rst_n(rst_n), .session(session),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_fail(rsp_fail));
    smp_link_props i_smp_link_props (.clk(clk), .rst_n(rst_n),
        .sck(lk.sck), .mosi(lk.mosi), .miso(lk.miso),
        .tgt_reset_n(lk.tgt_reset_n));

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            $display("unexpected cycle limit expected 80000 seen %0d", cyc);
            final_report();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    // one instruction through the command handshake, entered at negedge
    task automatic cmd(input logic [31:0] w);
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_valid = 1'b1;
        cmd_word = w;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge clk);
        r = rsp_word;
    endtask

    task automatic start_session();
        session = 1'b1;
        repeat (4) @(negedge clk);
        cmd(32'hac530000);
        chk("enable echo", 8'h53, r[15:8]);
        chk("enable fail", 8'h00, {7'h0, rsp_fail});
        chk("enabled", 8'h01, {7'h0, prog_enabled});
    endtask

    task automatic end_session();
        session = 1'b0;
        repeat (8) @(negedge clk);
        chk("enable dropped", 8'h00, {7'h0, prog_enabled});
    endtask

    // erase then writes refused until enable in a new session
    task automatic t_gate();
        start_session();
        cmd(32'hac800000);
        end_session();
        session = 1'b1;
        repeat (4) @(negedge clk);
        cmd(32'hc0000a3c);
        cmd(32'hac530000);
        cmd(32'ha0000a00);
        chk("write before enable", 8'hff, r[7:0]);
    endtask

    // low and high bytes of one word, then a word differing in the high address
    task automatic t_pm();
        cmd(32'h4005a312);
        chk("busy after wait", 8'h00, {7'h0, nv_busy});
        cmd(32'h4805a334);
        cmd(32'h2005a300);
        chk("pm low", 8'h12, r[7:0]);
        cmd(32'h2805a300);
        chk("pm high", 8'h34, r[7:0]);
        cmd(32'h2001a300);
        chk("pm other word", 8'hff, r[7:0]);
    endtask

    task automatic t_ee();
        cmd(32'hc000ffa5);
        cmd(32'ha000ff00);
        chk("ee top", 8'ha5, r[7:0]);
        cmd(32'ha000fe00);
        chk("ee neighbour", 8'hff, r[7:0]);
    endtask

    // fuse write, then undefined codes that must change nothing
    task automatic t_fuse();
        cmd(32'haca50000);
        cmd(32'hac000000);
        cmd(32'hff000000);
        cmd(32'h50000000);
        chk("fuse read", 8'h05, {2'b00, r[5:0]});
        chk("fuse port", 8'h05, {2'b00, fuse_bits});
        cmd(32'ha000ff00);
        chk("ee kept", 8'ha5, r[7:0]);
    endtask

    // signatures, lock programming, hiding, and erase clearing locks and both memories
    task automatic t_lock();
        logic [7:0] sig_exp [4];
        sig_exp = '{8'h5a, 8'h3c, 8'h0f, 8'hff};
        for (int i = 0; i < 4; i++) begin
            cmd({8'h30, 8'h00, 6'h00, i[1:0], 8'h00});
            chk("signature", sig_exp[i], r[7:0]);
        end
        cmd(32'hacfd0000);
        cmd(32'h58000000);
        chk("lock one", 8'h02, {6'h0, r[2:1]});
        cmd(32'h30000000);
        chk("sig partly locked", 8'h5a, r[7:0]);
        cmd(32'hacf90000);
        cmd(32'h58000000);
        chk("lock both", 8'h00, {6'h0, r[2:1]});
        chk("lock port", 8'h00, {6'h0, protect_bits});
        cmd(32'h30000100);
        chk("sig hidden", 8'h00, r[7:0]);
        cmd(32'hac9f0000);
        cmd(32'h58000000);
        chk("lock erased", 8'h03, {6'h0, r[2:1]});
        cmd(32'ha000ff00);
        chk("ee erased", 8'hff, r[7:0]);
        cmd(32'h2805a300);
        chk("pm erased", 8'hff, r[7:0]);
        // ff after erase is answered at once, nothing shifted
        cmd(32'hc01000ff);
        chk("ff write skipped", 8'h00, r[23:16]);
    endtask

    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_gate();
        t_pm();
        t_ee();
        t_fuse();
        t_lock();
        end_session();
        final_report();
    end
endmodule // tb
`default_nettype wire
